// file: rtcmux_host.sv
// Host-side model of the three open-drain pins with pull-ups
`timescale 1ns/1ps
module rtcmux_host (
  input wire logic p_o, // Primary drive level
  input wire logic p_oe, // Primary drive enable
  input wire logic s_o, // Secondary drive level
  input wire logic s_oe, // Secondary drive enable
  input wire logic t_o, // Timer drive level
  input wire logic t_oe, // Timer drive enable
  output logic p_lvl, // Primary wire level
  output logic s_lvl, // Secondary wire level
  output logic t_lvl, // Timer wire level
  output logic drive_hi // Pin actively driven high
);
  assign p_lvl = p_oe ? p_o : 1'b1;
  assign s_lvl = s_oe ? s_o : 1'b1;
  assign t_lvl = t_oe ? t_o : 1'b1;
  assign drive_hi = (p_oe & p_o) | (s_oe & s_o) | (t_oe & t_o);
endmodule // rtcmux_host

// file: rtcmux_pkg.sv
// Package with constants and types for the RTC interrupt output mux
package rtcmux_pkg;

  // Register offsets (word aligned byte addresses)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLEAR = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_PINS = 8'h10;

  // Control register field positions
  localparam int POS_SEL1 = 0;
  localparam int POS_SEL2 = 4;
  localparam int POS_STATIC1 = 8;
  localparam int POS_STATIC2 = 9;
  localparam int POS_SQ_ENABLE = 10;
  localparam int POS_TPOL = 11;
  localparam int POS_READY = 12;

  // Reset values
  localparam logic [12:0] RST_CONTROL = 13'h0300;
  localparam logic [2:0] RST_ENABLE = 3'h0;

  // Interrupt status bit positions
  localparam int EV_IRQ = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_TIMER = 2;

  // Primary select codes
  localparam logic [1:0] SEL1_STATIC = 2'h0;
  localparam logic [1:0] SEL1_INV_IRQ = 2'h1;
  localparam logic [1:0] SEL1_NALARM = 2'h2;
  localparam logic [1:0] SEL1_SQUARE = 2'h3;

  // Secondary select codes
  localparam logic [2:0] SEL2_STATIC = 3'h0;
  localparam logic [2:0] SEL2_INV_IRQ = 3'h1;
  localparam logic [2:0] SEL2_NALARM = 3'h2;
  localparam logic [2:0] SEL2_TIMER = 3'h3;
  localparam logic [2:0] SEL2_SQUARE = 3'h4;

  // Power-up hold state machine
  typedef enum logic [1:0] {
    RTCMUX_HOLD = 2'b01,
    RTCMUX_RUN = 2'b10
  } rtcmux_phase_t;

  // Software control fields
  typedef struct packed {
    logic ready;
    logic timer_polarity;
    logic square_wave_enable;
    logic secondary_static_level;
    logic primary_static_level;
    logic gap_hi; // Unused bit 7, reads zero
    logic [2:0] secondary_pin_select;
    logic [1:0] gap_lo; // Unused bits 3:2, read zero
    logic [1:0] primary_pin_select;
  } rtcmux_ctrl_t;

  // Synchroniser stages for four async inputs
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] val;
  } rtcmux_sync_t;

  // Whole module state
  typedef struct packed {
    rtcmux_phase_t phase;
    rtcmux_ctrl_t ctrl;
    rtcmux_sync_t sync;
    logic [2:0] status;
    logic [2:0] enable;
    logic [2:0] prev;
    logic [31:0] rdata;
    logic irq;
    logic primary_oe;
    logic secondary_oe;
    logic timer_oe;
  } rtcmux_state_t;

endpackage : rtcmux_pkg

// file: rtcmux_top.sv
// Output selection logic for the three open-drain RTC signal pins
`timescale 1ns/1ps
// Notes on behaviour
// - Primary pin only pulls low or releases
// - Primary pin held low until core ready
// - Primary select: static, inverted irq, inverted alarm
// - Square wave on primary only when enabled
// - Secondary select: static, inverted irq, inverted alarm, timer
// - Square wave on secondary only when enabled
// - Timer on secondary supports both polarities
// - Timer pin pulls low while timer active
// - Secondary pin open drain, may float
module rtcmux_top (
  input wire logic REF_CLK, // 200 MHz core clock
  input wire logic RSTN, // Async reset, active low
  input wire logic [7:0] ADDR, // Register byte address
  input wire logic [31:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [31:0] RDATA, // Read data, cycle after strobe
  input wire logic COMBINED_IRQ, // Combined interrupt, active high
  input wire logic ALARM_INTERRUPT, // Alarm interrupt, active high
  input wire logic COUNTDOWN_INTERRUPT, // Timer interrupt, active high
  input wire logic SQUARE_WAVE, // Square wave from generator
  output logic PRIMARY_IRQ_CLOCK_PIN_O, // Output level, always low
  output logic PRIMARY_IRQ_CLOCK_PIN_OE, // High while pulling low
  output logic SECONDARY_IRQ_PIN_O, // Output level, always low
  output logic SECONDARY_IRQ_PIN_OE, // High while pulling low
  output logic TIMER_IRQ_PIN_O, // Output level, always low
  output logic TIMER_IRQ_PIN_OE, // High while pulling low
  output logic IRQ // Level interrupt to local logic
);

  rtcmux_pkg::rtcmux_state_t st; // Registered state
  rtcmux_pkg::rtcmux_state_t next_st; // Next state
  logic [3:0] raw_in; // Async inputs bundle
  logic [2:0] events; // Synchronised event levels
  logic sel_wr; // Write decode helper

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bundle async inputs
  assign raw_in = {SQUARE_WAVE, COUNTDOWN_INTERRUPT, ALARM_INTERRUPT, COMBINED_IRQ};
  assign events = st.sync.val[2:0];
  assign sel_wr = WR && hit(ADDR, rtcmux_pkg::OFS_CONTROL);

  // Next state logic
  always_comb begin
    logic drive1; // Primary pin high wish
    logic drive2; // Secondary pin high wish
    logic sq_wave; // Filtered square wave
    next_st = st;
    drive1 = 1'b1;
    drive2 = 1'b1;
    sq_wave = st.sync.val[3];
    // Three stage synchroniser, accept when stages two and three agree
    next_st.sync.s1 = raw_in;
    next_st.sync.s2 = st.sync.s1;
    next_st.sync.s3 = st.sync.s2;
    for (int i = 0; i < 4; i++) begin
      if (st.sync.s2[i] == st.sync.s3[i]) begin
        next_st.sync.val[i] = st.sync.s3[i];
      end
    end
    // Control write
    if (sel_wr) begin
      next_st.ctrl = rtcmux_pkg::rtcmux_ctrl_t'(WDATA[12:0]);
      // Unused bits never stored
      next_st.ctrl.gap_hi = 1'b0;
      next_st.ctrl.gap_lo = 2'h0;
    end
    // Enable write
    if (WR && hit(ADDR, rtcmux_pkg::OFS_ENABLE)) begin
      next_st.enable = WDATA[2:0];
    end
    // Clear, then rising events set; set wins
    if (WR && hit(ADDR, rtcmux_pkg::OFS_CLEAR)) begin
      next_st.status = st.status & ~WDATA[2:0];
    end
    next_st.prev = events;
    next_st.status = next_st.status | (events & ~st.prev);
    next_st.irq = |(next_st.status & next_st.enable);
    // Read mux
    next_st.rdata = 32'h0000_0000;
    if (RD) begin
      if (hit(ADDR, rtcmux_pkg::OFS_CONTROL)) begin
        next_st.rdata = {19'h0, st.ctrl};
      end else if (hit(ADDR, rtcmux_pkg::OFS_STATUS)) begin
        next_st.rdata = {29'h0, st.status};
      end else if (hit(ADDR, rtcmux_pkg::OFS_ENABLE)) begin
        next_st.rdata = {29'h0, st.enable};
      end else if (hit(ADDR, rtcmux_pkg::OFS_PINS)) begin
        next_st.rdata = {28'h0, st.phase == rtcmux_pkg::RTCMUX_RUN,
          st.timer_oe, st.secondary_oe, st.primary_oe};
      end
    end
    unique case (st.phase)
      rtcmux_pkg::RTCMUX_HOLD: begin
        if (sel_wr ? WDATA[rtcmux_pkg::POS_READY] : st.ctrl.ready) begin
          next_st.phase = rtcmux_pkg::RTCMUX_RUN;
        end
      end
      rtcmux_pkg::RTCMUX_RUN: begin
        next_st.phase = rtcmux_pkg::RTCMUX_RUN;
      end
      default: begin
        next_st.phase = rtcmux_pkg::RTCMUX_HOLD;
      end
    endcase
    unique case (st.ctrl.primary_pin_select)
      rtcmux_pkg::SEL1_STATIC: drive1 = st.ctrl.primary_static_level;
      rtcmux_pkg::SEL1_INV_IRQ: drive1 = ~events[rtcmux_pkg::EV_IRQ];
      rtcmux_pkg::SEL1_NALARM: drive1 = ~events[rtcmux_pkg::EV_ALARM];
      rtcmux_pkg::SEL1_SQUARE: drive1 = st.ctrl.square_wave_enable ? sq_wave : 1'b1;
    endcase
    unique case (st.ctrl.secondary_pin_select)
      rtcmux_pkg::SEL2_STATIC: drive2 = st.ctrl.secondary_static_level;
      rtcmux_pkg::SEL2_INV_IRQ: drive2 = ~events[rtcmux_pkg::EV_IRQ];
      rtcmux_pkg::SEL2_NALARM: drive2 = ~events[rtcmux_pkg::EV_ALARM];
      // Polarity set: pin low while timer active
      rtcmux_pkg::SEL2_TIMER: drive2 = events[rtcmux_pkg::EV_TIMER] ^ st.ctrl.timer_polarity;
      rtcmux_pkg::SEL2_SQUARE: drive2 = st.ctrl.square_wave_enable ? sq_wave : 1'b1;
      default: drive2 = 1'b1;
    endcase
    next_st.primary_oe = (next_st.phase == rtcmux_pkg::RTCMUX_HOLD) || !drive1;
    next_st.secondary_oe = !drive2;
    next_st.timer_oe = events[rtcmux_pkg::EV_TIMER];
  end

  // State register
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
      st.phase <= rtcmux_pkg::RTCMUX_HOLD;
      st.ctrl <= rtcmux_pkg::RST_CONTROL;
      st.enable <= rtcmux_pkg::RST_ENABLE;
      st.primary_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; data lines constant low
  assign RDATA = st.rdata;
  assign IRQ = st.irq;
  assign PRIMARY_IRQ_CLOCK_PIN_OE = st.primary_oe;
  assign SECONDARY_IRQ_PIN_OE = st.secondary_oe;
  assign TIMER_IRQ_PIN_OE = st.timer_oe;
  assign PRIMARY_IRQ_CLOCK_PIN_O = 1'b0;
  assign SECONDARY_IRQ_PIN_O = 1'b0;
  assign TIMER_IRQ_PIN_O = 1'b0;

  // Assertions
  // All checks sample on the core clock and pause in reset

  AST_HOLD_LOW: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_HOLD |-> PRIMARY_IRQ_CLOCK_PIN_OE)
    else $error("Primary pin released during hold");

  AST_RUN_KEEPS: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN |=> st.phase == rtcmux_pkg::RTCMUX_RUN)
    else $error("Running phase left without reset");

  AST_OD1: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    PRIMARY_IRQ_CLOCK_PIN_O == 1'b0)
    else $error("Primary pin drives high");

  AST_OD2: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    SECONDARY_IRQ_PIN_O == 1'b0)
    else $error("Secondary pin drives high");

  AST_OD3: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    TIMER_IRQ_PIN_O == 1'b0)
    else $error("Timer pin drives high");

  AST_TIMER: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    TIMER_IRQ_PIN_OE == $past(events[rtcmux_pkg::EV_TIMER]))
    else $error("Timer pin mismatch");

  AST_P_STATIC: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN && st.ctrl.primary_pin_select == rtcmux_pkg::SEL1_STATIC
    |=> PRIMARY_IRQ_CLOCK_PIN_OE == !$past(st.ctrl.primary_static_level))
    else $error("Primary static wrong");

  AST_P_IRQ: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN && st.ctrl.primary_pin_select == rtcmux_pkg::SEL1_INV_IRQ
    && $stable(st.ctrl) |=> PRIMARY_IRQ_CLOCK_PIN_OE == $past(events[rtcmux_pkg::EV_IRQ]))
    else $error("Primary irq select wrong");

  AST_P_ALARM: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN && st.ctrl.primary_pin_select == rtcmux_pkg::SEL1_NALARM
    |=> PRIMARY_IRQ_CLOCK_PIN_OE == $past(events[rtcmux_pkg::EV_ALARM]))
    else $error("Primary alarm select wrong");

  AST_SQUARE1: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN && st.ctrl.primary_pin_select == rtcmux_pkg::SEL1_SQUARE
    && !st.ctrl.square_wave_enable |=> !PRIMARY_IRQ_CLOCK_PIN_OE)
    else $error("Square wave toggles primary while disabled");

  // Square wave on primary when enabled
  AST_P_SQUARE_ON: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.phase == rtcmux_pkg::RTCMUX_RUN && st.ctrl.primary_pin_select == rtcmux_pkg::SEL1_SQUARE
    && st.ctrl.square_wave_enable |=> PRIMARY_IRQ_CLOCK_PIN_OE == !$past(st.sync.val[3]))
    else $error("Primary square wave wrong");

  AST_SQUARE2: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_SQUARE
    && !st.ctrl.square_wave_enable |=> !SECONDARY_IRQ_PIN_OE)
    else $error("Square wave toggles secondary while disabled");

  // Square wave on secondary when enabled
  AST_S_SQUARE_ON: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_SQUARE
    && st.ctrl.square_wave_enable |=> SECONDARY_IRQ_PIN_OE == !$past(st.sync.val[3]))
    else $error("Secondary square wave wrong");

  AST_TPOL: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_TIMER
    |=> SECONDARY_IRQ_PIN_OE == ($past(events[rtcmux_pkg::EV_TIMER]) ~^ $past(st.ctrl.timer_polarity)))
    else $error("Timer polarity wrong");

  AST_S_STATIC: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_STATIC
    |=> SECONDARY_IRQ_PIN_OE == !$past(st.ctrl.secondary_static_level))
    else $error("Secondary static wrong");

  AST_S_IRQ: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_INV_IRQ
    |=> SECONDARY_IRQ_PIN_OE == $past(events[rtcmux_pkg::EV_IRQ]))
    else $error("Secondary irq select wrong");

  AST_S_ALARM: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_NALARM
    |=> SECONDARY_IRQ_PIN_OE == $past(events[rtcmux_pkg::EV_ALARM]))
    else $error("Secondary alarm select wrong");

  AST_S_RELEASE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select > rtcmux_pkg::SEL2_SQUARE |=> !SECONDARY_IRQ_PIN_OE)
    else $error("Unused secondary code drives pin");

  // Interrupt level follows enabled status
  AST_IRQ_LEVEL: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    IRQ == |(st.status & st.enable))
    else $error("Interrupt level wrong");

  // Read data zero outside read answers
  AST_RDATA_IDLE: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    !RD |=> RDATA == 32'h0000_0000)
    else $error("Read data not zero when idle");

  // Status read returns sticky bits
  AST_RD_STATUS: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR == rtcmux_pkg::OFS_STATUS |=> RDATA == {29'h0, $past(st.status)})
    else $error("Status read wrong");

  // Pin state read returns drive enables
  AST_RD_PINS: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR == rtcmux_pkg::OFS_PINS
    |=> RDATA[2:0] == $past({TIMER_IRQ_PIN_OE, SECONDARY_IRQ_PIN_OE, PRIMARY_IRQ_CLOCK_PIN_OE}))
    else $error("Pin state read wrong");

  // Reads above the map return zero
  AST_RD_UNMAPPED: assert property (@(posedge REF_CLK) disable iff (!RSTN)
    RD && ADDR > rtcmux_pkg::OFS_PINS |=> RDATA == 32'h0000_0000)
    else $error("Unmapped read not zero");

  // Per event: sticky until cleared, set wins over clear
  for (genvar i = 0; i < 3; i++) begin : g_sticky
    // Bit holds unless a clear names it
    AST_STICKY: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      st.status[i] && !(WR && hit(ADDR, rtcmux_pkg::OFS_CLEAR) && WDATA[i]) |=> st.status[i])
      else $error("Status bit lost without clear");
    // Rising event always sets the bit
    AST_SET_WINS: assert property (@(posedge REF_CLK) disable iff (!RSTN)
      events[i] && !st.prev[i] |=> st.status[i])
      else $error("Event did not set status");
  end

  // Covers
  COV_RUN: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    $rose(st.phase == rtcmux_pkg::RTCMUX_RUN));
  COV_IRQ: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(IRQ));
  COV_SQUARE: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.square_wave_enable && $rose(PRIMARY_IRQ_CLOCK_PIN_OE));
  COV_TIMER_POL: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    st.ctrl.secondary_pin_select == rtcmux_pkg::SEL2_TIMER && st.ctrl.timer_polarity && SECONDARY_IRQ_PIN_OE);
  COV_CLEAR: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    WR && hit(ADDR, rtcmux_pkg::OFS_CLEAR) && |st.status);

endmodule // rtcmux_top

// file: tb_top.sv
// Self-checking testbench for the RTC interrupt output mux
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0; // Core clock
  logic rstn = 1'b0; // Reset, active low
  logic [7:0] addr = 8'h00; // Bus address
  logic [31:0] wdata = 32'h0; // Bus write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [31:0] rdata; // Bus read data
  logic [3:0] ins = 4'h0; // Irq, alarm, timer, square wave
  logic p_o, p_oe, s_o, s_oe, t_o, t_oe, irq; // Design outputs
  logic p_lvl, s_lvl, t_lvl, drive_hi; // Wire view
  logic [31:0] rv; // Read value
  int miscompares = 0;
  int total_checks = 0;
  // Clock generator
  initial forever #2.5 ref_clk = ~ref_clk;
  rtcmux_top rtcmux_top_inst (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .COMBINED_IRQ(ins[3]), .ALARM_INTERRUPT(ins[2]), .COUNTDOWN_INTERRUPT(ins[1]),
    .SQUARE_WAVE(ins[0]), .PRIMARY_IRQ_CLOCK_PIN_O(p_o), .PRIMARY_IRQ_CLOCK_PIN_OE(p_oe),
    .SECONDARY_IRQ_PIN_O(s_o), .SECONDARY_IRQ_PIN_OE(s_oe), .TIMER_IRQ_PIN_O(t_o), .TIMER_IRQ_PIN_OE(t_oe),
    .IRQ(irq));
  rtcmux_host rtcmux_host_inst (.p_o(p_o), .p_oe(p_oe), .s_o(s_o), .s_oe(s_oe), .t_o(t_o), .t_oe(t_oe),
    .p_lvl(p_lvl), .s_lvl(s_lvl), .t_lvl(t_lvl), .drive_hi(drive_hi));
  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle register write
  task automatic bwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // One-cycle register read, data in the next cycle
  task automatic brd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Set control and inputs, then judge the pins
  task automatic apply(input logic [12:0] ctrl, input logic [3:0] val, input logic [2:0] exp);
    bwr(rtcmux_pkg::OFS_CONTROL, {19'h0, ctrl});
    ins <= val;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("pins", {29'h0, exp}, {29'h0, p_lvl, s_lvl, t_lvl});
    chk("drive high", 32'h0, {31'h0, drive_hi});
  endtask
  // Reset hold and register defaults
  task automatic t_reset();
    @(posedge ref_clk);
    #1;
    chk("reset pins", 32'h3, {29'h0, p_lvl, s_lvl, t_lvl});
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("primary before ready", 32'h0, {31'h0, p_lvl});
    brd(rtcmux_pkg::OFS_CONTROL, rv);
    chk("control reset", {19'h0, rtcmux_pkg::RST_CONTROL}, rv);
    brd(8'h20, rv);
    chk("unmapped read", 32'h0, rv);
  endtask
  // Primary sources
  task automatic t_primary();
    apply(13'h1300, 4'h0, 3'b111);
    apply(13'h1200, 4'h0, 3'b011);
    apply(13'h1301, 4'h8, 3'b011);
    apply(13'h1301, 4'h0, 3'b111);
    apply(13'h1302, 4'h4, 3'b011);
    apply(13'h1302, 4'h8, 3'b111);
  endtask
  // Secondary sources and timer pin
  task automatic t_secondary();
    apply(13'h1100, 4'h0, 3'b101);
    apply(13'h1310, 4'h8, 3'b101);
    apply(13'h1320, 4'h4, 3'b101);
    apply(13'h1320, 4'h8, 3'b111);
    apply(13'h1B30, 4'h2, 3'b100);
    apply(13'h1330, 4'h2, 3'b110);
    apply(13'h1330, 4'h0, 3'b101);
    apply(13'h1350, 4'hE, 3'b110);
  endtask
  // Square wave gated by its enable
  task automatic t_square();
    int lows;
    lows = 0;
    apply(13'h1343, 4'h0, 3'b111);
    repeat (40) begin
      @(posedge ref_clk);
      ins[0] <= ~ins[0];
      #1;
      lows = lows + ((p_lvl & s_lvl) ? 0 : 1);
    end
    chk("gated square wave", 32'h0, lows);
    apply(13'h1743, 4'h1, 3'b111);
    apply(13'h1743, 4'h0, 3'b001);
  endtask
  // Sticky status, enable mask and clear
  task automatic t_irq();
    ins <= 4'h0;
    bwr(rtcmux_pkg::OFS_CLEAR, 32'h7);
    bwr(rtcmux_pkg::OFS_ENABLE, 32'h1);
    ins <= 4'h4;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("masked irq", 32'h0, {31'h0, irq});
    ins <= 4'hC;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("enabled irq", 32'h1, {31'h0, irq});
    bwr(rtcmux_pkg::OFS_STATUS, 32'h0);
    brd(rtcmux_pkg::OFS_STATUS, rv);
    chk("status", 32'h3, rv);
    bwr(rtcmux_pkg::OFS_CLEAR, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("cleared irq", 32'h0, {31'h0, irq});
    brd(rtcmux_pkg::OFS_STATUS, rv);
    chk("status after clear", 32'h2, rv);
  endtask
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    t_reset();
    t_primary();
    t_secondary();
    t_square();
    t_irq();
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
endmodule // tb_top
